// ### rtl/ldm_gp_bank.v
`include "ldm_defs.vh"
// one 192-byte general purpose bank, flip-flop storage indexed by offset-40h
module ldm_gp_bank (
	// clock, reset, enable
	input  wire       clk_i,
	input  wire       nrst_i,
	input  wire       ce_i,
	// access port
	input  wire       we_i,
	input  wire [7:0] addr_i,
	input  wire [7:0] wdata_i,
	output wire [7:0] rdata_o
);
	reg  [7:0] mem_reg [0:191];   // storage
	wire [7:0] idx;               // offset within window
	integer    k;

	assign idx     = addr_i - `LDM_GP_LO;
	assign rdata_o = (idx < 8'd192) ? mem_reg[idx] : 8'h00;

	// write port; contents cleared at reset so reads are defined
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (k = 0; k < 192; k = k + 1)
				mem_reg[k] <= 8'h00;
		end else if (ce_i && we_i && (idx < 8'd192)) begin
			mem_reg[idx] <= wdata_i;
		end
	end
endmodule // ldm_gp_bank

// ### rtl/ldm_top.v
// Function
// - bank zero RAM at 40h..ffh, 192 bytes
// - bank codes 1..11 map 40h..ffh RAM
// - banked memory only via second pointer
// - bank 15: 80h..fbh display, bch..bfh unusable
// - display bit one lights its dot
// - sixty segments against eleven commons
// - build option: 11/10 commons, 1/4 or 1/5 bias
// - drive level written at offset 34h
// - segments 0..15 selectable as key-scan
// - control bit7 enables outputs, RAM untouched
// - control bit2 read-write detector enable
// - control bit4 reads battery-low state
// - control bits 0,1,3,5,6 read zero
// - commons 0..7 at 80h, 8..10 at c0h
// - unused display bits and holes read zero
`include "ldm_defs.vh"
module ldm_top #(
	parameter        COMS_ELEVEN = 1,   // 1: eleven commons, 0: ten
	parameter        BIAS_FIFTH  = 1    // 1: one-fifth bias, 0: one-quarter
) (
	// clock, reset, enable
	input  wire        clk_i,
	input  wire        nrst_i,
	input  wire        ce_i,
	// cpu data memory port
	input  wire        rd_i,
	input  wire        wr_i,
	input  wire [7:0]  addr_i,
	input  wire [7:0]  wdata_i,
	input  wire        ind_i,
	input  wire        ptr_sel_i,
	input  wire [3:0]  bank_select_field_i,
	output reg  [7:0]  rdata_o,
	// key-scan selection and analog sense
	input  wire [15:0] keyscan_sel_i,
	input  wire        battery_sense_low_i,
	// panel side
	output reg  [10:0] com_dot_o,
	output reg  [59:0] seg_dot_o,
	output reg  [15:0] keyscan_pin_sel_o,
	output reg         panel_output_enable_o,
	output reg         low_voltage_detect_enable_o,
	output reg  [3:0]  lcd_drive_level_o,
	output reg         coms_eleven_o,
	output reg         bias_fifth_o
);
	reg  [7:0]  first_memory_pointer_reg;    // first pointer
	reg  [7:0]  second_memory_pointer_reg;   // second pointer
	reg         ctl_on_reg;                  // panel enable
	reg         ctl_detect_reg;              // detector enable
	reg  [7:0]  drive_reg;                   // drive level register
	reg  [7:0]  disp_lo_reg [0:59];          // commons 0..7 per segment
	reg  [2:0]  disp_hi_reg [0:59];          // commons 8..10 per segment
	reg  [3:0]  scan_reg;                    // common being shown
	wire [7:0]  eff_addr;                    // resolved address
	wire [3:0]  eff_bank;                    // resolved bank
	wire        eff_ok;                      // access is permitted
	wire [7:0]  gp_rdata [0:11];             // bank read buses
	reg  [7:0]  rd_next;                     // read mux
	wire [7:0]  low_voltage_flag;            // low-voltage flag byte
	integer     i;                           // index, register process only
	integer     j;                           // segment index, scan process only
	genvar      g;

	// classify display offsets; shared by read and write paths
	function [1:0] disp_kind;   // 0 none, 1 low half, 2 high half
		input [7:0] a;
		begin
			if (a >= `LDM_DISP_LO && a < `LDM_DISP_HOLE_LO)
				disp_kind = 2'd1;
			else if (a >= `LDM_DISP_UPPER && a <= `LDM_DISP_HI)
				disp_kind = 2'd2;
			else
				disp_kind = 2'd0;
		end
	endfunction

	// display index from offset
	function [5:0] disp_idx;
		input [7:0] a;
		begin
			if (a >= `LDM_DISP_UPPER)
				disp_idx = a[5:0] - 6'h00;
			else
				disp_idx = a[5:0];
		end
	endfunction

	// indirect accesses use a pointer; direct ones see bank zero only
	assign eff_addr = ind_i ? (ptr_sel_i ? second_memory_pointer_reg
	                                     : first_memory_pointer_reg) : addr_i;
	assign eff_bank = (ind_i && ptr_sel_i) ? bank_select_field_i : `LDM_BANK_ZERO;
	assign eff_ok   = !(ind_i && !ptr_sel_i && bank_select_field_i != `LDM_BANK_ZERO)
	                  || (eff_addr < `LDM_GP_LO);
	assign low_voltage_flag = {3'b000, battery_sense_low_i, 4'h0};

	// twelve general purpose banks
	generate
		for (g = 0; g < 12; g = g + 1) begin : gp
			ldm_gp_bank u_bank (
				.clk_i   (clk_i),
				.nrst_i  (nrst_i),
				.ce_i    (ce_i),
				.we_i    (wr_i && eff_ok && eff_bank == g && eff_addr >= `LDM_GP_LO),
				.addr_i  (eff_addr),
				.wdata_i (wdata_i),
				.rdata_o (gp_rdata[g])
			);
		end
	endgenerate

	// read mux; unused bits and holes return zero
	always @* begin
		rd_next = 8'h00;
		if (ind_i && eff_addr <= `LDM_IND1_ADDR && !eff_addr[0]) begin
			rd_next = 8'h00;                          // indirect of indirect
		end else if (eff_bank == `LDM_BANK_DISPLAY) begin
			if (disp_kind(eff_addr) == 2'd1)
				rd_next = disp_lo_reg[disp_idx(eff_addr)];
			else if (disp_kind(eff_addr) == 2'd2)
				rd_next = {5'h00, disp_hi_reg[disp_idx(eff_addr)]};
		end else if (!eff_ok) begin
			rd_next = 8'h00;
		end else if (eff_addr >= `LDM_GP_LO && eff_bank <= `LDM_BANK_LAST) begin
			rd_next = gp_rdata[eff_bank];
		end else if (eff_bank == `LDM_BANK_ZERO) begin
			if (eff_addr == `LDM_LCD_CONTROL_ADDR)
				rd_next = {ctl_on_reg, 2'b00, 1'b0, 1'b0, ctl_detect_reg, 2'b00}
				          | low_voltage_flag;
			else if (eff_addr == `LDM_LCD_DRIVE_ADDR)
				rd_next = drive_reg;
			else if (eff_addr == `LDM_FIRST_PTR_ADDR)
				rd_next = first_memory_pointer_reg;
			else if (eff_addr == `LDM_SECOND_PTR_ADDR)
				rd_next = second_memory_pointer_reg;
		end
	end

	// registers, display RAM and read data
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			first_memory_pointer_reg  <= `LDM_PTR_RESET;
			second_memory_pointer_reg <= `LDM_PTR_RESET;
			ctl_on_reg                <= 1'b0;
			ctl_detect_reg            <= 1'b0;
			drive_reg                 <= `LDM_DRIVE_RESET;
			rdata_o                   <= 8'h00;
			for (i = 0; i < 60; i = i + 1) begin
				disp_lo_reg[i] <= 8'h00;
				disp_hi_reg[i] <= 3'h0;
			end
		end else if (ce_i) begin
			if (rd_i)
				rdata_o <= rd_next;
			if (wr_i && eff_bank == `LDM_BANK_ZERO && !ind_i) begin
				// direct writes to bank zero registers
				if (addr_i == `LDM_LCD_CONTROL_ADDR) begin
					ctl_on_reg   <= wdata_i[`LDM_CTL_ON_BIT];
					ctl_detect_reg <= wdata_i[`LDM_CTL_DETECT_BIT];
				end else if (addr_i == `LDM_LCD_DRIVE_ADDR)
					drive_reg <= wdata_i;
				else if (addr_i == `LDM_FIRST_PTR_ADDR)
					first_memory_pointer_reg <= wdata_i;
				else if (addr_i == `LDM_SECOND_PTR_ADDR)
					second_memory_pointer_reg <= wdata_i;
			end
			if (wr_i && eff_bank == `LDM_BANK_DISPLAY) begin
				// display writes; holes are dropped
				if (disp_kind(eff_addr) == 2'd1)
					disp_lo_reg[disp_idx(eff_addr)] <= wdata_i;
				else if (disp_kind(eff_addr) == 2'd2)
					disp_hi_reg[disp_idx(eff_addr)] <= wdata_i[2:0];
			end
		end
	end

	// common scan and panel outputs; enable never touches RAM
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			scan_reg                    <= 4'h0;
			com_dot_o                   <= 11'h000;
			seg_dot_o                   <= 60'h0;
			keyscan_pin_sel_o           <= 16'h0000;
			panel_output_enable_o       <= 1'b0;
			low_voltage_detect_enable_o <= 1'b0;
			lcd_drive_level_o           <= 4'h0;
			coms_eleven_o               <= 1'b0;
			bias_fifth_o                <= 1'b0;
		end else if (ce_i) begin
			// waveform shaping lies in the analog driver; we give the dot pattern
			if (scan_reg >= (COMS_ELEVEN ? 4'd10 : 4'd9))
				scan_reg <= 4'h0;
			else
				scan_reg <= scan_reg + 4'h1;
			coms_eleven_o               <= (COMS_ELEVEN != 0);
			bias_fifth_o                <= (BIAS_FIFTH != 0);
			panel_output_enable_o       <= ctl_on_reg;
			low_voltage_detect_enable_o <= ctl_detect_reg;
			lcd_drive_level_o           <= drive_reg[7:4];
			keyscan_pin_sel_o           <= keyscan_sel_i;
			if (!ctl_on_reg) begin
				com_dot_o <= 11'h000;
				seg_dot_o <= 60'h0;
			end else begin
				com_dot_o <= 11'h001 << scan_reg;
				for (j = 0; j < 60; j = j + 1) begin
					// key-scan pins carry no dot data; low index bits keep the select in range
					if (j < 16 && keyscan_sel_i[j[3:0]])
						seg_dot_o[j] <= 1'b0;
					else if (scan_reg < 4'd8)
						seg_dot_o[j] <= disp_lo_reg[j][scan_reg[2:0]];
					else
						seg_dot_o[j] <= disp_hi_reg[j][scan_reg[1:0]];
				end
			end
		end
	end
endmodule // ldm_top

// ### shared/ldm_defs.vh
`ifndef LDM_DEFS_VH
`define LDM_DEFS_VH
// register offsets in bank zero
`define LDM_LCD_CONTROL_ADDR    8'h2d
`define LDM_LCD_DRIVE_ADDR      8'h34
`define LDM_FIRST_PTR_ADDR      8'h01
`define LDM_SECOND_PTR_ADDR     8'h03
`define LDM_IND0_ADDR           8'h00
`define LDM_IND1_ADDR           8'h02
// general purpose window
`define LDM_GP_LO               8'h40
`define LDM_GP_HI               8'hff
// bank select codes
`define LDM_BANK_ZERO           4'h0
`define LDM_BANK_FIRST          4'h1
`define LDM_BANK_LAST           4'hb
`define LDM_BANK_DISPLAY        4'hf
// display window
`define LDM_DISP_LO             8'h80
`define LDM_DISP_HI             8'hfb
`define LDM_DISP_HOLE_LO        8'hbc
`define LDM_DISP_HOLE_HI        8'hbf
`define LDM_DISP_UPPER          8'hc0
// control register field positions
`define LDM_CTL_DETECT_BIT      2
`define LDM_CTL_FLAG_BIT        4
`define LDM_CTL_ON_BIT          7
// reset values
`define LDM_CTL_RESET           8'h00
`define LDM_DRIVE_RESET         8'h00
`define LDM_PTR_RESET           8'h00
// panel geometry
`define LDM_SEGS                60
`define LDM_COMS                11
`define LDM_KEYSEGS             16
`endif

// ### tb/ldm_checker.sv
module ldm_checker (
	// clock, reset, enable
	input wire logic        clk_i,
	input wire logic        nrst_i,
	input wire logic        ce_i,
	// cpu port
	input wire logic        rd_i,
	input wire logic        wr_i,
	input wire logic        ind_i,
	input wire logic [7:0]  addr_i,
	input wire logic [7:0]  wdata_i,
	input wire logic [7:0]  rdata_o,
	input wire logic [15:0] keyscan_sel_i,
	input wire logic        battery_sense_low_i,
	// panel side
	input wire logic [10:0] com_dot_o,
	input wire logic [59:0] seg_dot_o,
	input wire logic [15:0] keyscan_pin_sel_o,
	input wire logic        panel_output_enable_o,
	input wire logic        low_voltage_detect_enable_o,
	input wire logic [3:0]  lcd_drive_level_o,
	input wire logic        coms_eleven_o,
	input wire logic        bias_fifth_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// direct accesses to the two panel registers
	wire ctl_rd = ce_i && rd_i && !ind_i && addr_i == 8'h2d;
	wire ctl_wr = ce_i && wr_i && !ind_i && addr_i == 8'h2d;
	wire drv_wr = ce_i && wr_i && !ind_i && addr_i == 8'h34;
	chk_ctl_unused: assert property (ctl_rd |=> (rdata_o & 8'h6b) == 8'h00)
		else $error("control unused bits set");
	chk_low_flag: assert property (ctl_rd |=> rdata_o[4] == $past(battery_sense_low_i))
		else $error("low flag wrong");
	chk_out_enable: assert property (ctl_wr ##1 ce_i |=> panel_output_enable_o == $past(wdata_i[7], 2))
		else $error("output enable wrong");
	chk_detect_en: assert property (ctl_wr ##1 ce_i |=> low_voltage_detect_enable_o == $past(wdata_i[2], 2))
		else $error("detect enable wrong");
	chk_drive_level: assert property (drv_wr ##1 ce_i |=> lcd_drive_level_o == $past(wdata_i[7:4], 2))
		else $error("drive level wrong");
	// one cycle of lag is allowed while the enable copy settles
	chk_idle_off: assert property (!panel_output_enable_o && $past(!panel_output_enable_o)
		|-> com_dot_o == 11'h000 && seg_dot_o == 60'h0) else $error("outputs not idle");
	chk_one_common: assert property (panel_output_enable_o && $past(panel_output_enable_o)
		|-> $onehot(com_dot_o)) else $error("common not one-hot");
	chk_keyscan_sel: assert property (ce_i |=> keyscan_pin_sel_o == $past(keyscan_sel_i))
		else $error("keyscan select wrong");
	// a pin handed to key-scan must never carry a dot
	chk_keyscan_dark: assert property ((seg_dot_o[15:0] & keyscan_pin_sel_o) == 16'h0000)
		else $error("key-scan pin shows a dot");
	// build options are fixed: eleven commons, one-fifth bias
	chk_build_opts: assert property (ce_i |=> coms_eleven_o && bias_fifth_o)
		else $error("build option outputs wrong");
endmodule // ldm_checker
bind ldm_top ldm_checker ldm_checker_i (.clk_i, .nrst_i, .ce_i, .rd_i, .wr_i, .ind_i, .addr_i,
	.wdata_i, .rdata_o, .keyscan_sel_i, .battery_sense_low_i, .com_dot_o, .seg_dot_o,
	.keyscan_pin_sel_o, .panel_output_enable_o, .low_voltage_detect_enable_o, .lcd_drive_level_o,
	.coms_eleven_o, .bias_fifth_o);

// ### tb/ldm_panel_model.sv
module ldm_panel_model (
	// scan drive seen by the glass
	input wire logic        clk_i,
	input wire logic [10:0] com_i,
	input wire logic [59:0] seg_i,
	input wire logic        on_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [59:0] lit [11]; // last dots seen per common
	// glass only lights while driven; a set bit lights its dot
	always @(posedge clk_i)
		for (int c = 0; c < 11; c++)
			if (on_i && com_i[c])
				lit[c] <= seg_i;
endmodule // ldm_panel_model

// ### tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 0, nrst_i = 0, ce_i = 1, rd_i = 0, wr_i = 0, ind_i = 0, ptr_i = 0;
	logic        batt_i = 0;
	logic [3:0]  bank_i = 4'h0;
	logic [7:0]  addr_i = 8'h00, wdata_i = 8'h00, q, d, a;
	logic [7:0]  ofs [12];      // random offset per bank
	logic [7:0]  dv [128];      // display bank image
	logic [15:0] ks_i = 16'h0000;
	wire  [7:0]  rdata_o;
	wire  [10:0] com_o;
	wire  [59:0] seg_o;
	wire         en_o;
	int          miscompares = 0, n_checks = 0, cyc = 0, s;
	always #25 clk_i = ~clk_i;
	ldm_top ldm_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .rd_i(rd_i), .wr_i(wr_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .ind_i(ind_i), .ptr_sel_i(ptr_i),
		.bank_select_field_i(bank_i), .rdata_o(rdata_o), .keyscan_sel_i(ks_i),
		.battery_sense_low_i(batt_i), .com_dot_o(com_o), .seg_dot_o(seg_o),
		.keyscan_pin_sel_o(), .panel_output_enable_o(en_o), .low_voltage_detect_enable_o(),
		.lcd_drive_level_o(), .coms_eleven_o(), .bias_fifth_o());
	ldm_panel_model panel_i (.clk_i(clk_i), .com_i(com_o), .seg_i(seg_o), .on_i(en_o));
	task automatic cmp(input string what, input logic [7:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s at %0t got %h exp %h", what, $time, got, exp);
		end
	endtask
	// one access; sense and key-scan inputs move at random meanwhile
	task automatic op(input logic w, i, p, input logic [3:0] b, input logic [7:0] ad, dt);
		@(posedge clk_i);
		{wr_i, rd_i, ind_i, ptr_i, bank_i, addr_i, wdata_i} <= {w, !w, i, p, b, ad, dt};
		batt_i <= 1'($urandom);
		ks_i <= 16'($urandom);
		@(posedge clk_i);
		{wr_i, rd_i} <= 2'b00;
		#1 q = rdata_o;
	endtask
	// load a pointer directly, then go through it
	task automatic mem(input logic w, p, input logic [3:0] b, input logic [7:0] ad, dt);
		op(1, 0, 0, 4'h0, p ? 8'h03 : 8'h01, ad);
		op(w, 1, p, b, p ? 8'h02 : 8'h00, dt);
	endtask
	function automatic logic [7:0] pat(input logic [3:0] b, input logic [7:0] ad);
		return ad ^ {b, 4'h9};
	endfunction
	// bank zero direct, other banks only via the second pointer
	task automatic gp(input logic w, input logic [3:0] b, input logic [7:0] ad);
		if (b == 4'h0)
			op(w, 0, 0, b, ad, pat(b, ad));
		else
			mem(w, 1, b, ad, pat(b, ad));
	endtask
	function automatic logic [7:0] disp(input int x, input logic [7:0] v);
		if ((x >= 60 && x < 64) || x >= 124)
			return 8'h00;
		return x >= 64 ? v & 8'h07 : v;
	endfunction
	task automatic tally_and_finish;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// hang guard, a few times the expected run length
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	initial begin
		d = 8'($urandom(31));
		repeat (16) @(posedge clk_i);
		nrst_i <= 1;
		for (int n = 0; n < 12; n++) begin
			d = 8'($urandom);
			op(1, 0, 0, 4'h0, n % 2 ? 8'h34 : 8'h2d, d);
			op(0, 0, 0, 4'h0, n % 2 ? 8'h34 : 8'h2d, 8'h00);
			cmp("reg", q, n % 2 ? d : (d & 8'h84) | {3'b000, batt_i, 4'h0});
		end
		$display("test registers done");
		foreach (ofs[b])
			ofs[b] = 8'h40 + 8'($urandom % 192);
		for (int n = 0; n < 72; n++) begin
			a = n % 3 == 0 ? 8'h40 : n % 3 == 1 ? 8'hff : ofs[(n % 36) / 3];
			gp(n < 36, 4'((n % 36) / 3), a);
			if (n >= 36)
				cmp("bank", q, pat(4'((n % 36) / 3), a));
		end
		mem(0, 0, 4'h0, 8'hff, 8'h00);
		cmp("first ptr", q, pat(4'h0, 8'hff));
		mem(0, 0, 4'h5, 8'hff, 8'h00);
		cmp("first ptr", q, 8'h00);
		mem(1, 0, 4'h5, ofs[5], 8'h3c);
		gp(0, 4'h5, ofs[5]);
		cmp("first ptr", q, pat(4'h5, ofs[5]));
		$display("test banks done");
		foreach (dv[x]) begin
			dv[x] = 8'($urandom);
			mem(1, 1, 4'hf, 8'h80 + 8'(x), dv[x]);
		end
		foreach (dv[x]) begin
			mem(0, 1, 4'hf, 8'h80 + 8'(x), 8'h00);
			cmp("display", q, disp(x, dv[x]));
		end
		$display("test display ram done");
		op(1, 0, 0, 4'h0, 8'h2d, 8'h80);
		repeat (40) @(posedge clk_i) ce_i <= 1'($urandom);
		@(posedge clk_i) ce_i <= 1;
		repeat (14) @(posedge clk_i);
		for (int c = 0; c < 11; c++) begin
			s = 16 + $urandom % 44;
			cmp("dot", 8'(panel_i.lit[c][s]), 8'(c < 8 ? dv[s][c] : dv[64 + s][c - 8]));
		end
		$display("test panel done");
		op(1, 0, 0, 4'h0, 8'h2d, 8'h00);
		repeat (4) @(posedge clk_i);
		cmp("idle com", 8'(com_o), 8'h00);
		mem(0, 1, 4'hf, 8'h85, 8'h00);
		cmp("ram kept", q, dv[5]);
		$display("test disable done");
		tally_and_finish();
	end
endmodule // tb
